/* core/addr_calc.v */
`timescale 1ns/1ps
`default_nettype none
`include "dmb_exec_map.vh"
module addr_calc (
  // pointer and addressing mode
  input wire [15:0] ptr,
  input wire [1:0] mode,
  input wire [5:0] disp,
  input wire use_disp,
  // effective address and updated pointer
  output wire [15:0] addr,
  output wire [15:0] ptr_new
);
  // 16-bit sums wrap naturally across the whole pair [RULE_20]
  wire [15:0] ptr_inc = ptr + 16'h0001;
  wire [15:0] ptr_dec = ptr - 16'h0001;
  wire [15:0] ptr_disp = ptr + {10'h000, disp};

  // displacement leaves the pointer alone [RULE_06] [RULE_10]
  assign addr = use_disp ? ptr_disp :
                (mode == `PM_PRE_DEC) ? ptr_dec : ptr; // [RULE_05] [RULE_09]
  assign ptr_new = use_disp ? ptr :
                   (mode == `PM_POST_INC) ? ptr_inc : // [RULE_04] [RULE_08]
                   (mode == `PM_PRE_DEC) ? ptr_dec : ptr;
endmodule
`default_nettype wire

/* core/data_move_bit_ops_exec.v */
// Functional notes
// [RULE_01] jump_if_irq_on: if I set, pc += off+1; 1 cycle, 2 if taken.
// [RULE_02] jump_if_irq_off: if I clear, pc += off+1; 1/2 cycles, no flags.
// [RULE_03] reg_copy and pair_copy take one cycle and touch no flag.
// [RULE_04] post-increment load reads at pointer then bumps it; 2 cycles.
// [RULE_05] pre-decrement load drops pointer first, reads there; 2 cycles.
// [RULE_06] load_displaced on Y or Z reads pointer+q, pointer kept.
// [RULE_07] load_direct reads the absolute address in two cycles.
// [RULE_08] post-increment store writes at pointer then bumps it; 2 cycles.
// [RULE_09] pre-decrement store drops pointer then writes there; 2 cycles.
// [RULE_10] write_displaced on Y or Z writes pointer+q, pointer kept.
// [RULE_11] write_direct writes the absolute address in two cycles.
// [RULE_12] program_mem_read loads byte at Z, optional Z+1; 3 cycles.
// [RULE_13] push stores source on stack in two cycles, no flags.
// [RULE_14] pop loads top stack byte into destination in two cycles.
// [RULE_15] io_bit_set/io_bit_clear force one I/O bit; 2 cycles.
// [RULE_16] left shift inserts zero, rotate inserts carry; ZCNV updated.
// [RULE_17] right shift, signed shift, rotate right; one cycle each.
// [RULE_18] bit to transfer flag and back, one cycle each.
// [RULE_19] single-cycle set or clear of any one flag by index.
// [RULE_20] pointer updates wrap at 16 bits, written in same instruction.
`timescale 1ns/1ps
`default_nettype none
`include "dmb_exec_map.vh"
module data_move_bit_ops_exec #(
  parameter [15:0] SP_INIT = `SP_RESET
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // decoded instruction
  input wire instr_valid,
  input wire [4:0] instr_op,
  input wire [4:0] rd_idx,
  input wire [4:0] rr_idx,
  input wire [2:0] bit_idx,
  input wire [1:0] ptr_sel,
  input wire [1:0] ptr_mode,
  input wire [5:0] disp_q,
  input wire [15:0] addr_k,
  input wire [5:0] io_sel,
  input wire [6:0] br_off,
  // core state
  output wire busy,
  output wire [15:0] pc,
  output wire [7:0] cpu_flag_register,
  output wire [15:0] sp,
  // data memory
  output wire [15:0] dmem_addr,
  output wire [7:0] dmem_wdata,
  output wire dmem_we,
  output wire dmem_re,
  input wire [7:0] dmem_rdata,
  // program memory
  output wire [15:0] pmem_addr,
  output wire pmem_re,
  input wire [7:0] pmem_rdata,
  // i/o space
  output wire [5:0] io_addr,
  output wire [7:0] io_wdata,
  output wire io_re,
  output wire io_we,
  input wire [7:0] io_rdata,
  // register file peek
  input wire [4:0] dbg_idx,
  output wire [7:0] dbg_data
);
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_MEM = 5'b00010;
  localparam [4:0] S_PM1 = 5'b00100;
  localparam [4:0] S_PM2 = 5'b01000;
  localparam [4:0] S_IO = 5'b10000;

  function [4:0] ptr_lo;
    input [1:0] sel;
    begin
      ptr_lo = `PTR_BASE + {2'b00, sel, 1'b0};
    end
  endfunction

  reg [7:0] rf [0:31];
  reg [4:0] state_reg;
  reg busy_reg;
  reg [15:0] pc_reg;
  reg [7:0] flags_reg;
  reg [15:0] sp_reg;
  reg [15:0] dmem_addr_reg;
  reg [7:0] dmem_wdata_reg;
  reg dmem_we_reg;
  reg dmem_re_reg;
  reg [15:0] pmem_addr_reg;
  reg pmem_re_reg;
  reg [5:0] io_addr_reg;
  reg [7:0] io_wdata_reg;
  reg io_re_reg;
  reg io_we_reg;
  reg [7:0] dbg_data_reg;
  reg ld_pend_reg;
  reg [4:0] dst_reg;
  reg [2:0] io_bit_reg;
  reg io_set_reg;
  integer i;

  wire take = instr_valid & ~busy_reg;
  wire [4:0] plo = ptr_lo(ptr_sel);
  wire [4:0] phi = plo + 5'h01;
  wire [15:0] ptr_cur = {rf[phi], rf[plo]};
  wire [15:0] z_cur = {rf[5'h1F], rf[5'h1E]};
  wire is_disp = (instr_op == `OP_LD_DISP) | (instr_op == `OP_ST_DISP);
  // displacement exists only for Y and Z; an X request is dropped
  wire disp_ok = (ptr_sel == `PTR_Y) | (ptr_sel == `PTR_Z);
  wire ptr_upd = ~is_disp & (ptr_mode != `PM_PLAIN);
  wire [15:0] ea;
  wire [15:0] ptr_nx;
  wire [15:0] z_nx = z_cur + 16'h0001;
  wire [15:0] sp_inc = sp_reg + 16'h0001;
  wire [15:0] br_target = pc_reg + {{9{br_off[6]}}, br_off} + 16'h0001;
  wire [4:0] rd_even = {rd_idx[4:1], 1'b0};
  wire [4:0] rr_even = {rr_idx[4:1], 1'b0};
  wire [7:0] sh_res;
  wire sh_c;
  wire sh_z;
  wire sh_n;
  wire sh_v;
  wire [7:0] io_mask = 8'h01 << io_bit_reg;

  addr_calc u_addr (
    .ptr(ptr_cur),
    .mode(ptr_mode),
    .disp(disp_q),
    .use_disp(is_disp),
    .addr(ea),
    .ptr_new(ptr_nx)
  );

  shift_unit u_shift (
    .sel(instr_op[2:0]),
    .val(rf[rd_idx]),
    .cin(flags_reg[`FLAG_C]),
    .res(sh_res),
    .cout(sh_c),
    .zero(sh_z),
    .neg(sh_n),
    .ovf(sh_v)
  );

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < 32; i = i + 1) begin
        rf[i] <= 8'h00;
      end
      state_reg <= S_IDLE;
      busy_reg <= 1'b0;
      pc_reg <= 16'h0000;
      flags_reg <= `FLAGS_RESET;
      sp_reg <= SP_INIT;
      dmem_addr_reg <= 16'h0000;
      dmem_wdata_reg <= 8'h00;
      dmem_we_reg <= 1'b0;
      dmem_re_reg <= 1'b0;
      pmem_addr_reg <= 16'h0000;
      pmem_re_reg <= 1'b0;
      io_addr_reg <= 6'h00;
      io_wdata_reg <= 8'h00;
      io_re_reg <= 1'b0;
      io_we_reg <= 1'b0;
      dbg_data_reg <= 8'h00;
      ld_pend_reg <= 1'b0;
      dst_reg <= 5'h00;
      io_bit_reg <= 3'h0;
      io_set_reg <= 1'b0;
    end else begin
      // strobes live exactly one cycle
      dmem_we_reg <= 1'b0;
      dmem_re_reg <= 1'b0;
      pmem_re_reg <= 1'b0;
      io_re_reg <= 1'b0;
      io_we_reg <= 1'b0;
      dbg_data_reg <= rf[dbg_idx];
      case (state_reg)
        S_IDLE: begin
          if (take) begin
            pc_reg <= pc_reg + 16'h0001;
            case (instr_op)
              `OP_JMP_ION, `OP_JMP_IOFF: begin
                if (flags_reg[`FLAG_I] == (instr_op == `OP_JMP_ION)) begin
                  pc_reg <= br_target; // [RULE_01] [RULE_02]
                  busy_reg <= 1'b1;
                  state_reg <= S_MEM;
                end
              end
              `OP_REG_COPY: rf[rd_idx] <= rf[rr_idx]; // [RULE_03]
              `OP_PAIR_COPY: begin
                rf[rd_even] <= rf[rr_even]; // [RULE_03]
                rf[rd_even + 5'h01] <= rf[rr_even + 5'h01];
              end
              `OP_LD_PTR, `OP_LD_DISP, `OP_ST_PTR, `OP_ST_DISP: begin
                if (!is_disp || disp_ok) begin
                  dmem_addr_reg <= ea; // [RULE_04] [RULE_05] [RULE_06]
                  dst_reg <= rd_idx;
                  dmem_wdata_reg <= rf[rr_idx]; // [RULE_08] [RULE_10]
                  ld_pend_reg <= (instr_op == `OP_LD_PTR) |
                                 (instr_op == `OP_LD_DISP);
                  dmem_re_reg <= (instr_op == `OP_LD_PTR) |
                                 (instr_op == `OP_LD_DISP);
                  dmem_we_reg <= (instr_op == `OP_ST_PTR) |
                                 (instr_op == `OP_ST_DISP); // [RULE_09]
                  busy_reg <= 1'b1;
                  state_reg <= S_MEM;
                  if (ptr_upd) begin
                    rf[plo] <= ptr_nx[7:0]; // [RULE_20]
                    rf[phi] <= ptr_nx[15:8];
                  end
                end
              end
              `OP_LD_DIRECT, `OP_ST_DIRECT: begin
                // two-word forms: the address word is skipped too
                pc_reg <= pc_reg + 16'h0002;
                dmem_addr_reg <= addr_k; // [RULE_07] [RULE_11]
                dst_reg <= rd_idx;
                dmem_wdata_reg <= rf[rr_idx];
                ld_pend_reg <= (instr_op == `OP_LD_DIRECT);
                dmem_re_reg <= (instr_op == `OP_LD_DIRECT);
                dmem_we_reg <= (instr_op == `OP_ST_DIRECT);
                busy_reg <= 1'b1;
                state_reg <= S_MEM;
              end
              `OP_PM_READ: begin
                pmem_addr_reg <= z_cur; // [RULE_12]
                pmem_re_reg <= 1'b1;
                dst_reg <= rd_idx;
                busy_reg <= 1'b1;
                state_reg <= S_PM1;
                if (ptr_mode == `PM_POST_INC) begin
                  rf[5'h1E] <= z_nx[7:0]; // [RULE_20]
                  rf[5'h1F] <= z_nx[15:8];
                end
              end
              `OP_PUSH: begin
                dmem_addr_reg <= sp_reg; // [RULE_13]
                dmem_wdata_reg <= rf[rr_idx];
                dmem_we_reg <= 1'b1;
                sp_reg <= sp_reg - 16'h0001;
                busy_reg <= 1'b1;
                state_reg <= S_MEM;
              end
              `OP_POP: begin
                sp_reg <= sp_inc; // [RULE_14]
                dmem_addr_reg <= sp_inc;
                dmem_re_reg <= 1'b1;
                ld_pend_reg <= 1'b1;
                dst_reg <= rd_idx;
                busy_reg <= 1'b1;
                state_reg <= S_MEM;
              end
              `OP_IO_SET, `OP_IO_CLR: begin
                io_addr_reg <= io_sel; // [RULE_15]
                io_re_reg <= 1'b1;
                io_bit_reg <= bit_idx;
                io_set_reg <= (instr_op == `OP_IO_SET);
                busy_reg <= 1'b1;
                state_reg <= S_IO;
              end
              `OP_LSL, `OP_LSR, `OP_ROL, `OP_ROR, `OP_ASR: begin
                rf[rd_idx] <= sh_res; // [RULE_16] [RULE_17]
                flags_reg[`FLAG_C] <= sh_c;
                flags_reg[`FLAG_Z] <= sh_z;
                flags_reg[`FLAG_N] <= sh_n;
                flags_reg[`FLAG_V] <= sh_v;
              end
              `OP_BIT_TO_FLAG: begin
                flags_reg[`FLAG_T] <= rf[rr_idx][bit_idx]; // [RULE_18]
              end
              `OP_FLAG_TO_BIT: begin
                rf[rd_idx][bit_idx] <= flags_reg[`FLAG_T]; // [RULE_18]
              end
              `OP_FLAG_SET: flags_reg[bit_idx] <= 1'b1; // [RULE_19]
              `OP_FLAG_CLR: flags_reg[bit_idx] <= 1'b0; // [RULE_19]
              default: begin
                busy_reg <= 1'b0;
              end
            endcase
          end
        end
        S_MEM: begin
          // read data is sampled while the strobe is high
          if (ld_pend_reg) begin
            rf[dst_reg] <= dmem_rdata; // [RULE_04] [RULE_07] [RULE_14]
          end
          ld_pend_reg <= 1'b0;
          busy_reg <= 1'b0;
          state_reg <= S_IDLE;
        end
        S_PM1: begin
          state_reg <= S_PM2;
        end
        S_PM2: begin
          rf[dst_reg] <= pmem_rdata; // [RULE_12]
          busy_reg <= 1'b0;
          state_reg <= S_IDLE;
        end
        S_IO: begin
          // write is posted into the next instruction's first cycle
          io_wdata_reg <= io_set_reg ? (io_rdata | io_mask) :
                          (io_rdata & ~io_mask); // [RULE_15]
          io_we_reg <= 1'b1;
          busy_reg <= 1'b0;
          state_reg <= S_IDLE;
        end
        default: begin
          busy_reg <= 1'b0;
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  assign busy = busy_reg;
  assign pc = pc_reg;
  assign cpu_flag_register = flags_reg;
  assign sp = sp_reg;
  assign dmem_addr = dmem_addr_reg;
  assign dmem_wdata = dmem_wdata_reg;
  assign dmem_we = dmem_we_reg;
  assign dmem_re = dmem_re_reg;
  assign pmem_addr = pmem_addr_reg;
  assign pmem_re = pmem_re_reg;
  assign io_addr = io_addr_reg;
  assign io_wdata = io_wdata_reg;
  assign io_re = io_re_reg;
  assign io_we = io_we_reg;
  assign dbg_data = dbg_data_reg;
endmodule
`default_nettype wire

/* core/dmb_exec_map.vh */
`ifndef DMB_EXEC_MAP_VH
`define DMB_EXEC_MAP_VH
// instruction select codes on instr_op
`define OP_NOP 5'h00
`define OP_JMP_ION 5'h01
`define OP_JMP_IOFF 5'h02
`define OP_REG_COPY 5'h03
`define OP_PAIR_COPY 5'h04
`define OP_LD_PTR 5'h05
`define OP_LD_DISP 5'h06
`define OP_LD_DIRECT 5'h07
`define OP_ST_PTR 5'h08
`define OP_ST_DISP 5'h09
`define OP_ST_DIRECT 5'h0A
`define OP_PM_READ 5'h0B
`define OP_PUSH 5'h0C
`define OP_POP 5'h0D
`define OP_IO_SET 5'h0E
`define OP_IO_CLR 5'h0F
`define OP_LSL 5'h10
`define OP_LSR 5'h11
`define OP_ROL 5'h12
`define OP_ROR 5'h13
`define OP_ASR 5'h14
`define OP_BIT_TO_FLAG 5'h15
`define OP_FLAG_TO_BIT 5'h16
`define OP_FLAG_SET 5'h17
`define OP_FLAG_CLR 5'h18
// shifter select, low three bits of the shift codes
`define SH_LSL 3'h0
`define SH_LSR 3'h1
`define SH_ROL 3'h2
`define SH_ROR 3'h3
`define SH_ASR 3'h4
// pointer addressing modes on ptr_mode
`define PM_PLAIN 2'h0
`define PM_POST_INC 2'h1
`define PM_PRE_DEC 2'h2
// pointer pairs on ptr_sel
`define PTR_X 2'h0
`define PTR_Y 2'h1
`define PTR_Z 2'h2
`define PTR_BASE 5'h1A
// flag positions in the cpu flag register
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7
`define FLAGS_RESET 8'h00
`define SP_RESET 16'hFFFF
`endif

/* core/shift_unit.v */
`timescale 1ns/1ps
`default_nettype none
`include "dmb_exec_map.vh"
module shift_unit (
  // operand
  input wire [2:0] sel,
  input wire [7:0] val,
  input wire cin,
  // result and flags
  output reg [7:0] res,
  output reg cout,
  output wire zero,
  output wire neg,
  output wire ovf
);
  always @* begin
    res = val;
    cout = cin;
    case (sel)
      `SH_LSL: begin
        res = {val[6:0], 1'b0}; // [RULE_16]
        cout = val[7];
      end
      `SH_ROL: begin
        res = {val[6:0], cin}; // [RULE_16]
        cout = val[7];
      end
      `SH_LSR: begin
        res = {1'b0, val[7:1]}; // [RULE_17]
        cout = val[0];
      end
      `SH_ROR: begin
        res = {cin, val[7:1]}; // [RULE_17]
        cout = val[0];
      end
      `SH_ASR: begin
        res = {val[7], val[7:1]}; // [RULE_17]
        cout = val[0];
      end
      default: begin
        res = val;
        cout = cin;
      end
    endcase
  end

  assign zero = (res == 8'h00);
  assign neg = res[7];
  // overflow as sign-versus-carry mismatch, the usual shift convention
  assign ovf = res[7] ^ cout;
endmodule
`default_nettype wire

/* tb/dmb_exec_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dmb_exec_map.vh"
module dmb_exec_chk (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // instruction
  input wire logic instr_valid,
  input wire logic [4:0] instr_op,
  input wire logic [2:0] bit_idx,
  input wire logic [15:0] addr_k,
  input wire logic [6:0] br_off,
  // state
  input wire logic busy,
  input wire logic [15:0] pc,
  input wire logic [7:0] cpu_flag_register,
  input wire logic [15:0] sp,
  // memories
  input wire logic [15:0] dmem_addr,
  input wire logic dmem_we,
  input wire logic dmem_re,
  input wire logic io_re,
  input wire logic io_we,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  wire logic tk = instr_valid && !busy;
  wire logic ion = cpu_flag_register[`FLAG_I];
  wire logic [15:0] off_ext = {{9{br_off[6]}}, br_off};
  ld_two_cycle_a: assert property (tk && instr_op == `OP_LD_PTR |=>
    busy && dmem_re ##1 !busy && !dmem_re) else $error("load length");
  pm_three_a: assert property (tk && instr_op == `OP_PM_READ |=>
    busy[*2] ##1 !busy) else $error("program read length");
  shift_single_a: assert property (tk && instr_op >= `OP_LSL &&
    instr_op <= `OP_ASR |=> !busy) else $error("shift length");
  copy_flags_a: assert property (tk && (instr_op == `OP_REG_COPY ||
    instr_op == `OP_PAIR_COPY) |=> !busy && $stable(cpu_flag_register))
    else $error("copy changed flags");
  jump_on_a: assert property (tk && instr_op == `OP_JMP_ION && ion |=>
    busy && pc == $past(pc) + $past(off_ext) + 16'h1 ##1 !busy)
    else $error("taken branch on set");
  jump_off_a: assert property (tk && instr_op == `OP_JMP_IOFF && !ion |=>
    busy && pc == $past(pc) + $past(off_ext) + 16'h1 ##1 !busy)
    else $error("taken branch on clear");
  no_jump_a: assert property (tk && (instr_op == `OP_JMP_ION && !ion ||
    instr_op == `OP_JMP_IOFF && ion) |=> !busy && pc == $past(pc) + 16'h1)
    else $error("branch not taken");
  push_addr_a: assert property (tk && instr_op == `OP_PUSH |=> dmem_we &&
    dmem_addr == $past(sp) && sp == $past(sp) - 16'h1) else $error("push");
  pop_addr_a: assert property (tk && instr_op == `OP_POP |=> dmem_re &&
    sp == $past(sp) + 16'h1 && dmem_addr == sp) else $error("pop");
  st_direct_a: assert property (tk && instr_op == `OP_ST_DIRECT |=>
    dmem_we && dmem_addr == $past(addr_k)) else $error("direct store");
  io_set_a: assert property (tk && instr_op == `OP_IO_SET |=> io_re ##1
    io_we && io_wdata == ($past(io_rdata) | (8'h01 << $past(bit_idx, 2))))
    else $error("io bit set");
  io_clr_a: assert property (tk && instr_op == `OP_IO_CLR |=> io_re ##1
    io_we && io_wdata == ($past(io_rdata) & ~(8'h01 << $past(bit_idx, 2))))
    else $error("io bit clear");
  pm_seen_c: cover property (tk && instr_op == `OP_PM_READ);
  jump_seen_c: cover property (tk && instr_op == `OP_JMP_ION && ion);
  io_seen_c: cover property (tk && instr_op == `OP_IO_CLR);
endmodule
bind data_move_bit_ops_exec dmb_exec_chk u_dmb_exec_chk (.clk, .arst_n,
  .instr_valid, .instr_op, .bit_idx, .addr_k, .br_off, .busy, .pc,
  .cpu_flag_register, .sp, .dmem_addr, .dmem_we, .dmem_re, .io_re, .io_we,
  .io_wdata, .io_rdata);
`default_nettype wire

/* tb/tb_data_move_bit_ops_exec.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dmb_exec_map.vh"
module tb_data_move_bit_ops_exec;
  logic clk = 1'b0, arst_n = 1'b0, instr_valid = 1'b0;
  logic [4:0] instr_op = 5'h00, rd_idx = 5'h00, rr_idx = 5'h00;
  logic [4:0] dbg_idx = 5'h00;
  logic [2:0] bit_idx = 3'h0;
  logic [1:0] ptr_sel = 2'h0, ptr_mode = 2'h0;
  logic [5:0] disp_q = 6'h00, io_sel = 6'h00;
  logic [15:0] addr_k = 16'h0000;
  logic [6:0] br_off = 7'h00;
  logic [7:0] pmem_rdata = 8'h00, v, e;
  logic c, c2;
  logic [15:0] la = 16'h0000, lw = 16'h0000, iw = 16'h0000, p, f;
  logic [15:0] nacc = 16'h0000, ncyc;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  wire logic busy, dmem_we, dmem_re, pmem_re, io_re, io_we;
  wire logic [15:0] pc, sp, dmem_addr, pmem_addr;
  wire logic [7:0] cpu_flag_register, dmem_wdata, io_wdata, dbg_data;
  wire logic [5:0] io_addr;
  // read data turns over when not strobed so stale values never match
  wire logic [7:0] dm_val = dmem_addr[7:0] ^ 8'h3C;
  wire logic [7:0] dmem_rdata = dmem_re ? dm_val : ~dm_val;
  wire logic [7:0] io_rdata = io_re ? 8'h0F : 8'hF0;
  wire logic [15:0] dbg16 = {8'h00, dbg_data};
  wire logic [15:0] fl16 = {8'h00, cpu_flag_register};
  always #2 clk = ~clk;
  always @(posedge clk) begin
    pmem_rdata <= pmem_re ? pmem_addr[7:0] + 8'h11 : ~pmem_rdata;
    if (dmem_re | dmem_we) begin
      la <= dmem_addr;
      nacc <= nacc + 16'h1;
    end
    // write data only on a real write, so a store that reads is caught
    if (dmem_we) lw <= {8'h00, dmem_wdata};
    if (io_we) iw <= {8'h00, io_wdata};
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      close_out();
    end
  end
  data_move_bit_ops_exec u_data_move_bit_ops_exec (.clk(clk),
    .arst_n(arst_n), .instr_valid(instr_valid), .instr_op(instr_op),
    .rd_idx(rd_idx), .rr_idx(rr_idx), .bit_idx(bit_idx), .ptr_sel(ptr_sel),
    .ptr_mode(ptr_mode), .disp_q(disp_q), .addr_k(addr_k), .io_sel(io_sel),
    .br_off(br_off), .busy(busy), .pc(pc), .cpu_flag_register(cpu_flag_register),
    .sp(sp), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_we(dmem_we),
    .dmem_re(dmem_re), .dmem_rdata(dmem_rdata), .pmem_addr(pmem_addr),
    .pmem_re(pmem_re), .pmem_rdata(pmem_rdata), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_re(io_re), .io_we(io_we), .io_rdata(io_rdata),
    .dbg_idx(dbg_idx), .dbg_data(dbg_data));
  task close_out;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task ck(input logic [15:0] g, input logic [15:0] x);
    n_compared++;
    if (g !== x) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // one instruction, counted until busy falls
  task ex(input logic [4:0] o, input logic [4:0] d, input logic [4:0] r,
          input logic [2:0] b, input logic [15:0] k);
    // an idle edge first, so valid never falls and rises in one step
    @(posedge clk) #1;
    instr_op = o;
    rd_idx = d;
    rr_idx = r;
    bit_idx = b;
    addr_k = k;
    instr_valid = 1'b1;
    @(posedge clk) #1;
    instr_valid = 1'b0;
    ncyc = 16'h1;
    while (busy === 1'b1 && ncyc < 16'h8) begin
      @(posedge clk) #1;
      ncyc++;
    end
  endtask
  task pk(input logic [4:0] i);
    dbg_idx = i;
    @(posedge clk) #1;
  endtask
  task t_flags;
    for (int i = 0; i < 8; i++) begin
      ex(`OP_FLAG_SET, 5'h00, 5'h00, i[2:0], 16'h0000);
      ck(fl16, 16'h0001 << i);
      ck(ncyc, 16'h0001);
      ex(`OP_FLAG_CLR, 5'h00, 5'h00, i[2:0], 16'h0000);
      ck(fl16, 16'h0000);
    end
  endtask
  task t_branch;
    ex(`OP_FLAG_SET, 5'h00, 5'h00, `FLAG_I, 16'h0000);
    p = pc;
    br_off = 7'h05;
    ex(`OP_JMP_ION, 5'h00, 5'h00, 3'h0, 16'h0000);
    ck(pc, p + 16'h6);
    ck(ncyc, 16'h2);
    ex(`OP_JMP_IOFF, 5'h00, 5'h00, 3'h0, 16'h0000);
    ck(pc, p + 16'h7);
    ck(ncyc, 16'h1);
    ex(`OP_FLAG_CLR, 5'h00, 5'h00, `FLAG_I, 16'h0000);
    p = pc;
    br_off = 7'h7D;
    ex(`OP_JMP_IOFF, 5'h00, 5'h00, 3'h0, 16'h0000);
    ck(pc, p - 16'h2);
    ck(fl16, 16'h0000);
    ex(`OP_JMP_ION, 5'h00, 5'h00, 3'h0, 16'h0000);
    ck(pc, p - 16'h1);
  endtask
  task t_load;
    p = pc;
    ex(`OP_LD_DIRECT, 5'h01, 5'h00, 3'h0, 16'h0010);
    ck(pc, p + 16'h2);
    pk(5'h01);
    ck(dbg16, 16'h002C);
    ex(`OP_LD_DIRECT, 5'h1A, 5'h00, 3'h0, 16'h003C);
    ex(`OP_LD_DIRECT, 5'h1B, 5'h00, 3'h0, 16'h003C);
    ptr_sel = `PTR_X;
    ptr_mode = `PM_PRE_DEC;
    ex(`OP_LD_PTR, 5'h02, 5'h00, 3'h0, 16'h0000);
    ck(la, 16'hFFFF);
    ck(ncyc, 16'h2);
    ptr_mode = `PM_POST_INC;
    ex(`OP_LD_PTR, 5'h03, 5'h00, 3'h0, 16'h0000);
    ck(la, 16'hFFFF);
    pk(5'h1B);
    ck(dbg16, 16'h0000);
    pk(5'h03);
    ck(dbg16, 16'h00C3);
  endtask
  task t_disp;
    ex(`OP_LD_DIRECT, 5'h1C, 5'h00, 3'h0, 16'h003D);
    ptr_sel = `PTR_Y;
    disp_q = 6'h3F;
    ex(`OP_LD_DISP, 5'h07, 5'h00, 3'h0, 16'h0000);
    ck(la, 16'h0040);
    pk(5'h07);
    ck(dbg16, 16'h007C);
    pk(5'h1C);
    ck(dbg16, 16'h0001);
    ptr_sel = `PTR_Z;
    disp_q = 6'h05;
    ex(`OP_ST_DISP, 5'h00, 5'h01, 3'h0, 16'h0000);
    ck(la, 16'h0005);
    ck(lw, 16'h002C);
    ptr_sel = `PTR_X;
    p = nacc;
    ex(`OP_LD_DISP, 5'h07, 5'h00, 3'h0, 16'h0000);
    pk(5'h07);
    ck(nacc, p);
  endtask
  task t_store;
    ptr_mode = `PM_POST_INC;
    ex(`OP_ST_PTR, 5'h00, 5'h01, 3'h0, 16'h0000);
    ck(la, 16'h0000);
    ptr_mode = `PM_PRE_DEC;
    ex(`OP_ST_PTR, 5'h00, 5'h03, 3'h0, 16'h0000);
    ck(la, 16'h0000);
    ck(lw, 16'h00C3);
    ptr_mode = `PM_PLAIN;
    ex(`OP_ST_PTR, 5'h00, 5'h02, 3'h0, 16'h0000);
    pk(5'h1A);
    ck(dbg16, 16'h0000);
    ex(`OP_ST_DIRECT, 5'h00, 5'h01, 3'h0, 16'h1234);
    ck(la, 16'h1234);
    ck(ncyc, 16'h2);
  endtask
  task t_stack;
    f = fl16;
    ex(`OP_PUSH, 5'h00, 5'h01, 3'h0, 16'h0000);
    ck(la, 16'hFFFF);
    ck(sp, 16'hFFFE);
    ex(`OP_POP, 5'h04, 5'h00, 3'h0, 16'h0000);
    pk(5'h04);
    ck(dbg16, 16'h00C3);
    ck(sp, 16'hFFFF);
    ck(fl16, f);
  endtask
  task t_pm;
    ptr_mode = `PM_POST_INC;
    ex(`OP_PM_READ, 5'h05, 5'h00, 3'h0, 16'h0000);
    ck(ncyc, 16'h3);
    ptr_mode = `PM_PLAIN;
    ex(`OP_PM_READ, 5'h00, 5'h00, 3'h0, 16'h0000);
    pk(5'h05);
    ck(dbg16, 16'h0011);
    pk(5'h00);
    ck(dbg16, 16'h0012);
  endtask
  task t_shift;
    v = 8'hC3;
    c = cpu_flag_register[`FLAG_C];
    for (int i = 0; i < 5; i++) begin
      case (i)
        0: {c2, e} = {v, 1'b0};
        1: {e, c2} = {1'b0, v};
        2: {c2, e} = {v, c};
        3: {e, c2} = {c, v};
        default: {e, c2} = {v[7], v};
      endcase
      ex(`OP_LSL + i[4:0], 5'h04, 5'h04, 3'h0, 16'h0000);
      pk(5'h04);
      ck(dbg16, {8'h00, e});
      ck(fl16 & 16'h000F, {12'h000, e[7] ^ c2, e[7], e == 8'h00, c2});
      v = e;
      c = c2;
    end
  endtask
  task t_bits_copy;
    ex(`OP_BIT_TO_FLAG, 5'h00, 5'h01, 3'h2, 16'h0000);
    ck(fl16 & 16'h0040, 16'h0040);
    ex(`OP_FLAG_TO_BIT, 5'h03, 5'h00, 3'h5, 16'h0000);
    ck(ncyc, 16'h1);
    pk(5'h03);
    ck(dbg16, 16'h00E3);
    f = fl16;
    ex(`OP_REG_COPY, 5'h06, 5'h01, 3'h0, 16'h0000);
    ex(`OP_PAIR_COPY, 5'h08, 5'h04, 3'h0, 16'h0000);
    pk(5'h06);
    ck(dbg16, 16'h002C);
    pk(5'h08);
    ck(dbg16, {8'h00, v});
    pk(5'h09);
    ck(dbg16, 16'h0011);
    ck(fl16, f);
  endtask
  task t_io;
    io_sel = 6'h21;
    ex(`OP_IO_SET, 5'h00, 5'h00, 3'h7, 16'h0000);
    ck(ncyc, 16'h2);
    ck({10'h000, io_addr}, 16'h0021);
    @(posedge clk) #1;
    ck(iw, 16'h008F);
    ex(`OP_IO_CLR, 5'h00, 5'h00, 3'h0, 16'h0000);
    @(posedge clk) #1;
    ck(iw, 16'h000E);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 arst_n = 1'b1;
    ck(sp, 16'hFFFF);
    ck(pc, 16'h0000);
    t_flags();
    t_branch();
    t_load();
    t_disp();
    t_store();
    t_stack();
    t_pm();
    t_shift();
    t_bits_copy();
    t_io();
    close_out();
  end
endmodule
`default_nettype wire
